// [core/rsc_pkg.sv]
// Package for the reset and shutdown control block: register map, field positions,
// reset values and timing counts. Shared by the design and the bench.
package rsc_pkg;

    // Register indices on the plain register port (word addresses)
    localparam logic [3:0] ADDR_POWER_MODE   = 4'h0;
    localparam logic [3:0] ADDR_RST_FIRST    = 4'h1;
    localparam logic [3:0] ADDR_RST_SECOND   = 4'h2;
    localparam logic [3:0] ADDR_CLK_CTRL     = 4'h3;
    localparam logic [3:0] ADDR_STATUS       = 4'h4;

    // Power mode field encodings
    localparam logic [2:0] PM_ACTIVE         = 3'h0;
    localparam logic [2:0] PM_DEEP_SLEEP     = 3'h2;
    localparam logic [2:0] PM_BACKUP         = 3'h4;
    localparam logic [2:0] PM_SHUTDOWN       = 3'h7;
    localparam int         PM_LSB            = 0;
    localparam int         STORAGE_EN_BIT    = 8;

    // First reset control register fields
    localparam int         RST_PERIPH_BIT    = 0;
    localparam int         RST_SOFT_BIT      = 1;
    localparam int         RST_SYS_BIT       = 2;
    localparam int         RST_LP_LSB        = 8;
    localparam int         RST_LP_WIDTH      = 3;
    localparam int         RST_PER_LSB       = 16;
    localparam int         RST_PER_WIDTH     = 16;

    // Clock control fields: oscillator enables and system source select
    localparam int         CLK_SEL_LSB       = 0;
    localparam int         CLK_INTERNAL_BAUD_RATE_OSC_BIT      = 4;
    localparam int         CLK_EXTERNAL_HIGH_FREQ_OSC_BIT      = 5;
    localparam int         CLK_EXTERNAL_TIMEKEEPING_OSC_BIT     = 6;
    localparam logic [2:0] SRC_PRIMARY       = 3'h0;
    localparam logic [31:0] CLK_CTRL_RESET   = 32'h0000_0000;

    // Status fields
    localparam int         ST_LAST_LSB       = 0;
    localparam int         ST_PM_LSB         = 4;

    // Reset scopes, widest first in priority
    typedef enum logic [2:0] {
        RSC_SCOPE_NONE   = 3'b000,
        RSC_SCOPE_PERIPH = 3'b001,
        RSC_SCOPE_SOFT   = 3'b010,
        RSC_SCOPE_SYS    = 3'b011,
        RSC_SCOPE_POR    = 3'b100
    } rsc_scope_e;

    // Length of the scope reset pulses sent to the domains; the per-peripheral reset bits last one cycle
    localparam int         PULSE_NS          = 100;
    localparam int         CLK_PERIOD_NS     = 25;
    localparam logic [3:0] PULSE_CYCLES      = 4'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// [core/rsc_reset_shutdown_control.sv]
// Reset scope generator and shutdown control for the microcontroller.
// Assumes: rst_i is the power-on reset (supply cycling), watchdog events come
// from the same clock domain, the reset pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_shutdown_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Reset sources and power events
    input  wire logic        ext_reset_pin_n_i,
    input  wire logic [1:0]  watchdog_reset_i,
    input  wire logic        standby_exit_i,
    input  wire logic        deep_sleep_exit_i,
    // Reset outputs to the domains, active high
    output logic             periph_reset_o,
    output logic             lp_periph_reset_o,
    output logic [15:0]      per_periph_reset_o,
    output logic [15:0]      per_periph_reset2_o,
    output logic             gpio_reset_o,
    output logic             cpu_reset_o,
    output logic             watchdog_reset_o,
    output logic             global_ctrl_reset_o,
    output logic             always_on_reset_o,
    output logic             ram_retention_reset_o,
    output logic             fetch_vector_o,
    // Power and clock state
    output logic             core_power_on_o,
    output logic             always_on_power_on_o,
    output logic             ram_power_on_o,
    output logic             wakeup_enable_o,
    output logic             irq_enable_o,
    output logic             bus_clk_on_o,
    output logic             cpu_clk_on_o,
    output logic [2:0]       power_mode_o,
    output logic [2:0]       system_osc_source_sel_o,
    output logic             restore_active_o
);

    // ==========================================================
    // Reset pin synchroniser
    // ==========================================================
    logic [2:0] pin_sync;
    logic       pin_asserted;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_sync <= 3'h7;
        end else begin
            pin_sync <= {pin_sync[1:0], ext_reset_pin_n_i};
        end
    end

    logic pin_level;
    logic pin_level_q;
    // Second and third stage agree before the level changes
    assign pin_level = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_level_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_level_q <= 1'b1;
        end else begin
            pin_level_q <= pin_level;
        end
    end
    // Only the falling edge of the filtered pin requests a reset, so a pin held
    // low gives one pulse of standard length rather than an endless one
    assign pin_asserted = pin_level_q && !pin_level;

    // ==========================================================
    // Register decode
    // ==========================================================
    logic        in_shutdown;
    logic [2:0]  power_mode;
    logic        storage_en;
    logic [31:0] clk_ctrl;
    logic [31:0] rst_second;
    logic [2:0]  last_scope;

    wire wr_pm     = wr_i && (addr_i == rsc_pkg::ADDR_POWER_MODE);
    wire wr_rst1   = wr_i && (addr_i == rsc_pkg::ADDR_RST_FIRST);
    wire wr_rst2   = wr_i && (addr_i == rsc_pkg::ADDR_RST_SECOND);
    wire wr_clk    = wr_i && (addr_i == rsc_pkg::ADDR_CLK_CTRL);
    wire [2:0] wr_mode = wdata_i[rsc_pkg::PM_LSB +: 3];

    // Shutdown entry needs no handshake: the write itself is the trigger
    wire go_shutdown = wr_pm && (wr_mode == rsc_pkg::PM_SHUTDOWN);

    // Reset requests; everything is ignored once in shutdown
    wire req_periph = wr_rst1 && wdata_i[rsc_pkg::RST_PERIPH_BIT];
    wire req_soft   = wr_rst1 && wdata_i[rsc_pkg::RST_SOFT_BIT];
    wire req_sys    = (wr_rst1 && wdata_i[rsc_pkg::RST_SYS_BIT])
                      || pin_asserted || (|watchdog_reset_i)
                      || standby_exit_i;

    // Widest scope among simultaneous requests
    rsc_pkg::rsc_scope_e next_scope;
    always_comb begin
        if (in_shutdown) begin
            next_scope = rsc_pkg::RSC_SCOPE_NONE;
        end else if (req_sys) begin
            next_scope = rsc_pkg::RSC_SCOPE_SYS;
        end else if (req_soft) begin
            next_scope = rsc_pkg::RSC_SCOPE_SOFT;
        end else if (req_periph) begin
            next_scope = rsc_pkg::RSC_SCOPE_PERIPH;
        end else begin
            next_scope = rsc_pkg::RSC_SCOPE_NONE;
        end
    end

    wire sc_sys  = (next_scope == rsc_pkg::RSC_SCOPE_SYS);
    wire sc_soft = sc_sys  || (next_scope == rsc_pkg::RSC_SCOPE_SOFT);
    wire sc_per  = sc_soft || (next_scope == rsc_pkg::RSC_SCOPE_PERIPH);

    wire [15:0] sel_per1 = (wr_rst1 && !in_shutdown) ?
                           wdata_i[rsc_pkg::RST_PER_LSB +: rsc_pkg::RST_PER_WIDTH] : 16'h0000;
    wire [15:0] sel_per2 = (wr_rst2 && !in_shutdown) ? wdata_i[15:0] : 16'h0000;

    // ==========================================================
    // Control state
    // ==========================================================
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_shutdown <= 1'b0;
            power_mode  <= rsc_pkg::PM_ACTIVE;
            storage_en  <= 1'b0;
            clk_ctrl    <= rsc_pkg::CLK_CTRL_RESET;
            rst_second  <= 32'h0000_0000;
            last_scope  <= 3'(rsc_pkg::RSC_SCOPE_POR);
        end else if (in_shutdown) begin
            in_shutdown <= 1'b1;
        end else if (go_shutdown) begin
            in_shutdown <= 1'b1;
            power_mode  <= rsc_pkg::PM_SHUTDOWN;
        end else if (sc_sys) begin
            // Global control registers and clocks back to defaults
            power_mode  <= rsc_pkg::PM_ACTIVE;
            storage_en  <= 1'b0;
            clk_ctrl    <= rsc_pkg::CLK_CTRL_RESET;
            last_scope  <= 3'(next_scope);
        end else begin
            if (sc_per) begin
                // Peripheral and soft resets leave globals alone
                last_scope <= 3'(next_scope);
            end
            if (wr_pm) begin
                power_mode <= wr_mode;
                storage_en <= wdata_i[rsc_pkg::STORAGE_EN_BIT];
            end
            if (deep_sleep_exit_i) begin
                power_mode <= rsc_pkg::PM_ACTIVE;
            end
            if (wr_clk) begin
                clk_ctrl <= wdata_i;
            end
            if (wr_rst2) begin
                rst_second <= wdata_i;
            end
        end
    end

    // ==========================================================
    // Reset pulse stretcher, one counter each for the peripheral, soft and system scopes
    // ==========================================================
    logic [3:0] cnt_per;
    logic [3:0] cnt_soft;
    logic [3:0] cnt_sys;
    logic [15:0] per1_q;
    logic [15:0] per2_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_per  <= 4'h0;
            cnt_soft <= 4'h0;
            cnt_sys  <= 4'h0;
            per1_q   <= 16'h0000;
            per2_q   <= 16'h0000;
        end else begin
            cnt_per  <= sc_per  ? rsc_pkg::PULSE_CYCLES : ((cnt_per  != 4'h0) ? cnt_per  - 4'h1 : 4'h0);
            cnt_soft <= sc_soft ? rsc_pkg::PULSE_CYCLES : ((cnt_soft != 4'h0) ? cnt_soft - 4'h1 : 4'h0);
            cnt_sys  <= sc_sys  ? rsc_pkg::PULSE_CYCLES : ((cnt_sys  != 4'h0) ? cnt_sys  - 4'h1 : 4'h0);
            per1_q   <= sel_per1;
            per2_q   <= sel_per2;
        end
    end

    // ==========================================================
    // Registered outputs
    // ==========================================================
    wire per_on  = sc_per  || (cnt_per  > 4'h1);
    wire soft_on = sc_soft || (cnt_soft > 4'h1);
    wire sys_on  = sc_sys  || (cnt_sys  > 4'h1);
    wire live    = !(in_shutdown || go_shutdown);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Power-on reset hits every domain
            periph_reset_o        <= 1'b1;
            lp_periph_reset_o     <= 1'b1;
            per_periph_reset_o    <= 16'hFFFF;
            per_periph_reset2_o   <= 16'hFFFF;
            gpio_reset_o          <= 1'b1;
            cpu_reset_o           <= 1'b1;
            watchdog_reset_o      <= 1'b1;
            global_ctrl_reset_o   <= 1'b1;
            always_on_reset_o     <= 1'b1;
            ram_retention_reset_o <= 1'b1;
            fetch_vector_o        <= 1'b1;
            core_power_on_o       <= 1'b1;
            always_on_power_on_o  <= 1'b1;
            ram_power_on_o        <= 1'b1;
            wakeup_enable_o       <= 1'b0;
            irq_enable_o          <= 1'b0;
            bus_clk_on_o          <= 1'b1;
            cpu_clk_on_o          <= 1'b1;
            power_mode_o          <= rsc_pkg::PM_ACTIVE;
            system_osc_source_sel_o         <= rsc_pkg::SRC_PRIMARY;
            restore_active_o      <= 1'b0;
            rdata_o               <= 32'h0000_0000;
        end else begin
            periph_reset_o        <= per_on;
            // Low-power peripherals follow peripheral/soft, not system
            lp_periph_reset_o     <= (sc_per && !sc_sys) || (cnt_per > 4'h1 && cnt_sys == 4'h0);
            per_periph_reset_o    <= sel_per1;
            per_periph_reset2_o   <= sel_per2;
            gpio_reset_o          <= soft_on;
            cpu_reset_o           <= sys_on;
            watchdog_reset_o      <= sys_on;
            global_ctrl_reset_o   <= sys_on;
            always_on_reset_o     <= 1'b0;
            ram_retention_reset_o <= 1'b0;
            fetch_vector_o        <= sys_on;
            core_power_on_o       <= live;
            always_on_power_on_o  <= live;
            ram_power_on_o        <= live;
            wakeup_enable_o       <= live;
            irq_enable_o          <= live;
            bus_clk_on_o          <= live;
            cpu_clk_on_o          <= live;
            power_mode_o          <= go_shutdown ? rsc_pkg::PM_SHUTDOWN : power_mode;
            system_osc_source_sel_o         <= sc_sys ? rsc_pkg::SRC_PRIMARY : clk_ctrl[rsc_pkg::CLK_SEL_LSB +: 3];
            restore_active_o      <= deep_sleep_exit_i && live;
            rdata_o               <= 32'h0000_0000;
            if (rd_i) begin
                unique case (addr_i)
                    rsc_pkg::ADDR_POWER_MODE: rdata_o <= {23'h0, storage_en, 5'h0, power_mode};
                    rsc_pkg::ADDR_RST_FIRST:  rdata_o <= {per1_q, 16'h0000};
                    rsc_pkg::ADDR_RST_SECOND: rdata_o <= rst_second;
                    rsc_pkg::ADDR_CLK_CTRL:   rdata_o <= clk_ctrl;
                    rsc_pkg::ADDR_STATUS:     rdata_o <= {25'h0, power_mode, 1'b0, last_scope};
                    default:                  rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // rsc_reset_shutdown_control

`default_nettype wire

// [dv/rsc_checker.sv]
// Assertion checker for the reset and shutdown control block.
// Assumes: bound to the top module, one clock, rst_i is the power-on reset.
`timescale 1ns/1ps
`default_nettype none

module rsc_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic [1:0]  watchdog_reset_i,
    input wire logic        periph_reset_o,
    input wire logic        lp_periph_reset_o,
    input wire logic        gpio_reset_o,
    input wire logic        cpu_reset_o,
    input wire logic        watchdog_reset_o,
    input wire logic        global_ctrl_reset_o,
    input wire logic        always_on_reset_o,
    input wire logic        core_power_on_o,
    input wire logic        always_on_power_on_o,
    input wire logic        ram_power_on_o,
    input wire logic        wakeup_enable_o,
    input wire logic        irq_enable_o,
    input wire logic [2:0]  system_osc_source_sel_o
);
    // ==========================================
    // Decode and sequences
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic pm_off = wr_i && addr_i == rsc_pkg::ADDR_POWER_MODE && wdata_i[2:0] == rsc_pkg::PM_SHUTDOWN;
    wire logic rst_wr = wr_i && addr_i == rsc_pkg::ADDR_RST_FIRST && core_power_on_o;
    sequence pulse4;
        periph_reset_o [*4];
    endsequence
    sequence dropped;
        !periph_reset_o;
    endsequence

    // ==========================================
    // Assertions
    AST_SHUTDOWN_ENTRY: assert property (pm_off |=> !core_power_on_o && !always_on_power_on_o && !ram_power_on_o)
        else $error("Shutdown write left power on");
    AST_SHUTDOWN_QUIET: assert property (!ram_power_on_o |-> !wakeup_enable_o && !irq_enable_o)
        else $error("Wake-up or interrupt enabled in shutdown");
    AST_SHUTDOWN_HOLD: assert property (!core_power_on_o |=> !core_power_on_o && !cpu_reset_o)
        else $error("Shutdown left without power-on reset");
    AST_PULSE_LEN: assert property ($rose(periph_reset_o) |-> pulse4 ##1 dropped)
        else $error("Peripheral reset pulse length wrong");
    AST_PERIPH_SCOPE: assert property (rst_wr && wdata_i[2:0] == 3'h1 |=> periph_reset_o && lp_periph_reset_o
        && !gpio_reset_o && !cpu_reset_o && !watchdog_reset_o && !global_ctrl_reset_o)
        else $error("Peripheral reset scope wrong");
    AST_SOFT_SCOPE: assert property (rst_wr && wdata_i[2:0] == 3'h2 |=> gpio_reset_o && periph_reset_o && !cpu_reset_o)
        else $error("Soft reset scope wrong");
    AST_SYS_NEST: assert property (cpu_reset_o && !$past(rst_i) |-> periph_reset_o && gpio_reset_o
        && watchdog_reset_o && global_ctrl_reset_o && !lp_periph_reset_o && !always_on_reset_o)
        else $error("System reset scope wrong");
    AST_WDT_SYS: assert property (|watchdog_reset_i && core_power_on_o |-> ##[1:2] cpu_reset_o)
        else $error("Watchdog event gave no system reset");
    AST_AON_POR: assert property (always_on_reset_o |-> $past(rst_i))
        else $error("Always-on reset outside power-on reset");
    AST_OSC_DEFAULT: assert property ($fell(cpu_reset_o) |-> system_osc_source_sel_o == rsc_pkg::SRC_PRIMARY)
        else $error("Primary oscillator not selected after reset");
endmodule // rsc_checker

bind rsc_reset_shutdown_control rsc_checker u_chk (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .watchdog_reset_i,
    .periph_reset_o, .lp_periph_reset_o, .gpio_reset_o, .cpu_reset_o, .watchdog_reset_o, .global_ctrl_reset_o,
    .always_on_reset_o, .core_power_on_o, .always_on_power_on_o, .ram_power_on_o, .wakeup_enable_o,
    .irq_enable_o, .system_osc_source_sel_o);

`default_nettype wire

// [dv/rsc_reset_shutdown_control_tb.sv]
// Self-checking bench for the reset and shutdown control block.
// Assumes: the checker is bound to the design; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_shutdown_control_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0, rdata_o;
    logic        wr_i = 1'b0, rd_i = 1'b0, ext_reset_pin_n_i = 1'b1, standby_exit_i = 1'b0;
    logic        deep_sleep_exit_i = 1'b0;
    logic [1:0]  watchdog_reset_i = 2'h0;
    logic [15:0] per_periph_reset_o, per_periph_reset2_o;
    logic [2:0]  power_mode_o, system_osc_source_sel_o;
    logic        periph_reset_o, lp_periph_reset_o, gpio_reset_o, cpu_reset_o, watchdog_reset_o;
    logic        global_ctrl_reset_o, always_on_reset_o, ram_retention_reset_o, fetch_vector_o, core_power_on_o;
    logic        always_on_power_on_o, ram_power_on_o, wakeup_enable_o, irq_enable_o, bus_clk_on_o;
    logic        cpu_clk_on_o, restore_active_o;
    integer      seed = 45;
    int          n_fail = 0, n_compared = 0, cyc = 0;
    wire logic [6:0] vec = {periph_reset_o, lp_periph_reset_o, gpio_reset_o, cpu_reset_o, watchdog_reset_o,
                            global_ctrl_reset_o, fetch_vector_o};
    wire logic [6:0] pwr = {core_power_on_o, always_on_power_on_o, ram_power_on_o, wakeup_enable_o,
                            irq_enable_o, bus_clk_on_o, cpu_clk_on_o};

    rsc_reset_shutdown_control u_dut (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ext_reset_pin_n_i, .watchdog_reset_i, .standby_exit_i, .deep_sleep_exit_i, .periph_reset_o,
        .lp_periph_reset_o, .per_periph_reset_o, .per_periph_reset2_o, .gpio_reset_o, .cpu_reset_o,
        .watchdog_reset_o, .global_ctrl_reset_o, .always_on_reset_o, .ram_retention_reset_o, .fetch_vector_o,
        .core_power_on_o, .always_on_power_on_o, .ram_power_on_o, .wakeup_enable_o, .irq_enable_o,
        .bus_clk_on_o, .cpu_clk_on_o, .power_mode_o, .system_osc_source_sel_o, .restore_active_o);

    always #12.5 clk_i = ~clk_i;

    // ==========================================
    // Helpers
    function automatic rsc_pkg::rsc_scope_e widest(input logic [2:0] b);
        return b[2] ? rsc_pkg::RSC_SCOPE_SYS : b[1] ? rsc_pkg::RSC_SCOPE_SOFT :
               b[0] ? rsc_pkg::RSC_SCOPE_PERIPH : rsc_pkg::RSC_SCOPE_NONE;
    endfunction
    // Nesting: each wider scope adds domains, only system spares low-power peripherals
    function automatic logic [6:0] exp_vec(input rsc_pkg::rsc_scope_e s);
        return {s != rsc_pkg::RSC_SCOPE_NONE, s == rsc_pkg::RSC_SCOPE_PERIPH || s == rsc_pkg::RSC_SCOPE_SOFT,
                s == rsc_pkg::RSC_SCOPE_SOFT || s == rsc_pkg::RSC_SCOPE_SYS, {4{s == rsc_pkg::RSC_SCOPE_SYS}}};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task print_verdict;
        $display("Counts: %0d compared, %0d failed", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Roughly 240 cycles are needed; the ceiling leaves wide margin
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict;
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] r;
        rsc_pkg::rsc_scope_e s;
        int k;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        idle(2);
        chk(pwr, 7'h7F);
        chk({power_mode_o, system_osc_source_sel_o}, {rsc_pkg::PM_ACTIVE, rsc_pkg::SRC_PRIMARY});
        chk({always_on_reset_o, ram_retention_reset_o}, 2'h0);
        $display("Test power-on done");
        for (int i = 0; i < 8; i++) begin
            d = ($random(seed) & 32'hFFFF_0000) | 32'(i);
            s = widest(d[2:0]);
            wr(rsc_pkg::ADDR_RST_SECOND, d >> 16);
            chk(per_periph_reset2_o, d[31:16]);
            wr(rsc_pkg::ADDR_CLK_CTRL, 32'h1);
            idle(6);
            wr(rsc_pkg::ADDR_RST_FIRST, d);
            chk(vec, exp_vec(s));
            chk(per_periph_reset_o, d[31:16]);
            idle(6);
            chk(system_osc_source_sel_o, (s == rsc_pkg::RSC_SCOPE_SYS) ? rsc_pkg::SRC_PRIMARY : 3'h1);
            chk({pwr, power_mode_o}, {7'h7F, rsc_pkg::PM_ACTIVE});
            rd(rsc_pkg::ADDR_STATUS, r);
            if (s != rsc_pkg::RSC_SCOPE_NONE)
                chk(r[2:0], s);
        end
        $display("Test software resets done");
        for (int j = 0; j < 4; j++) begin
            @(posedge clk_i);
            watchdog_reset_i <= (j < 2) ? 2'(1 << j) : 2'h0;
            standby_exit_i <= (j == 2);
            ext_reset_pin_n_i <= (j != 3);
            // The pin filter needs two agreeing samples, so hold it low longer
            repeat ((j == 3) ? 3 : 1) @(posedge clk_i);
            watchdog_reset_i <= 2'h0;
            standby_exit_i <= 1'b0;
            ext_reset_pin_n_i <= 1'b1;
            #1;
            k = 0;
            while (cpu_reset_o !== 1'b1 && k < 10) begin
                @(posedge clk_i);
                #1;
                k++;
            end
            chk(vec, exp_vec(rsc_pkg::RSC_SCOPE_SYS));
            idle(8);
        end
        $display("Test reset sources done");
        wr(rsc_pkg::ADDR_POWER_MODE, 32'(rsc_pkg::PM_DEEP_SLEEP));
        @(posedge clk_i);
        deep_sleep_exit_i <= 1'b1;
        @(posedge clk_i);
        deep_sleep_exit_i <= 1'b0;
        #1;
        chk({restore_active_o, cpu_reset_o}, 2'b10);
        idle(1);
        chk(power_mode_o, rsc_pkg::PM_ACTIVE);
        rd(4'hF, r);
        chk(r, 32'h0);
        $display("Test deep sleep done");
        wr(rsc_pkg::ADDR_POWER_MODE, 32'(rsc_pkg::PM_SHUTDOWN));
        chk(pwr, 7'h00);
        wr(rsc_pkg::ADDR_RST_FIRST, 32'h4);
        @(posedge clk_i);
        standby_exit_i <= 1'b1;
        @(posedge clk_i);
        standby_exit_i <= 1'b0;
        idle(4);
        chk({vec, pwr}, 14'h0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        idle(2);
        chk({always_on_reset_o, ram_retention_reset_o}, 2'h3);
        @(posedge clk_i);
        rst_i <= 1'b0;
        idle(2);
        chk(pwr, 7'h7F);
        $display("Test shutdown done");
        print_verdict;
    end
endmodule // rsc_reset_shutdown_control_tb

`default_nettype wire
